// *** verilog/rtc_command_access.sv ***
// Purpose: Command decode, burst transfers and time update of a serial RTC
// Assumes: secTick is a one-cycle ref_clk pulse once per second
// Notes: SCLK logic is its own domain; CS high resets it asynchronously, holding registers excepted
// Functional notes
// - Command arrives MSB first; bit 7 low means write, high means read.
// - Command bit 6 selects clock registers (0) or scratch RAM (1).
// - Command bits 5..1 give the register or RAM index.
// - Command bit 0 must be one; when zero, write data is ignored.
// - Clock burst moves seconds..year then control, seconds MSB first.
// - Clock burst write applies only after all eight bytes arrive.
// - RAM burst walks all 31 locations from the first one.
// - Each RAM burst write byte is stored once its eight bits arrive.
// - RAM burst read sends bytes until 31 sent or chip select rises.
// - Time writes are buffered and loaded when chip select rises.
// - Incomplete time writes are discarded at chip select rise.
// - Time load and seconds increment never happen in one cycle.
// - Counters advance from the loaded values at the next tick.
// - Hours bit 7 high selects 12-hour, low selects 24-hour format.
// - Hours bit 5 is PM in 12-hour, tens bit for 20..23 in 24-hour.
// - Protection bit set blocks all writes except to itself.
// - Control bits 0..6 ignore writes and read as zero.
// - Time read latches counters at command, clear of any increment.
// - Clock burst read latches seven registers; century excluded.
// - Input sampled on rising SCLK, output changed on falling SCLK.
// - Serial output idle unless a read command runs with CS low.
`timescale 1ns/100ps

module rtc_command_access (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic secTick,
   input wire logic sclk,
   input wire logic csB,
   input wire logic din,
   output logic dout,
   output logic doutOeB
);

   rtc_access_pkg::rise_t r_q;
   rtc_access_pkg::rise_t r_d;
   rtc_access_pkg::fall_t f_q;
   rtc_access_pkg::fall_t f_d;
   rtc_access_pkg::core_t c_q;
   rtc_access_pkg::core_t c_d;
   logic [6:0] preHold_q;
   logic [7:0] byteHold_q;
   logic [7:0] ram [rtc_access_pkg::RAM_WORDS];
   logic csRise;
   logic preEv;
   logic fullEv;
   logic tickReq;
   logic tickApply;
   logic timeLoad;
   logic ramWe;
   logic [4:0] ramWrAddr;
   logic [7:0] ramWrData;
   logic [4:0] ramRdAddr;
   logic [5:0] dataIdx;

   function automatic logic isBurst(input logic [7:0] c);
      return c[rtc_access_pkg::CMD_IDX_HI:rtc_access_pkg::CMD_IDX_LO] ==
         rtc_access_pkg::IDX_BURST;
   endfunction : isBurst

   function automatic logic [8:0] bcdInc(input logic [7:0] v,
      input logic [7:0] maxV, input logic [7:0] minV);
      if (v == maxV) begin
         return {1'b1, minV};
      end else if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         return {1'b0, v + 8'h01};
      end
   endfunction : bcdInc

   function automatic logic [6:0][7:0] incTime(input logic [6:0][7:0] t);
      logic [8:0] s;
      logic [8:0] m;
      logic [8:0] h;
      logic pm;
      logic [6:0][7:0] n;
      n = t;
      s = bcdInc(t[0], rtc_access_pkg::SEC_MAX, rtc_access_pkg::BCD_ZERO);
      n[0] = s[7:0];
      if (s[8]) begin
         m = bcdInc(t[1], rtc_access_pkg::SEC_MAX, rtc_access_pkg::BCD_ZERO);
         n[1] = m[7:0];
         if (m[8]) begin
            if (t[2][rtc_access_pkg::HOUR_FMT_BIT]) begin
               h = bcdInc({3'b000, t[2][4:0]}, rtc_access_pkg::HOUR12_MAX,
                  rtc_access_pkg::HOUR12_MIN);
               pm = t[2][rtc_access_pkg::HOUR_PM_BIT] ^
                  (t[2][4:0] == rtc_access_pkg::HOUR11[4:0]);
               n[2] = {t[2][7:6], pm, h[4:0]};
            end else begin
               h = bcdInc({2'b00, t[2][5:0]}, rtc_access_pkg::HOUR24_MAX,
                  rtc_access_pkg::BCD_ZERO);
               n[2] = {t[2][7:6], h[5:0]};
            end
         end
      end
      return n;
   endfunction : incTime

   // Rising SCLK: shift in command and data bits
   always_comb begin
      r_d = r_q;
      r_d.shiftIn = {r_q.shiftIn[5:0], din};
      r_d.bitCnt = r_q.bitCnt + 3'h1;
      if (r_q.bitCnt == 3'h7 && r_q.byteCnt != rtc_access_pkg::COUNT_MAX) begin
         r_d.byteCnt = r_q.byteCnt + 6'h01;
      end
      if (r_q.bitCnt == 3'h0 && r_q.byteCnt == 6'h00) begin
         r_d.cmdRead = din;
      end
      r_d.preLvl = (r_q.bitCnt == 3'h6);
      r_d.fullLvl = (r_q.bitCnt == 3'h7);
   end

   always_ff @(posedge sclk or posedge csB) begin
      if (csB) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // Holding registers stay put across CS rise for the core to read
   always_ff @(posedge sclk) begin
      if (r_q.bitCnt == 3'h6) begin
         preHold_q <= {r_q.shiftIn[5:0], din};
      end
      if (r_q.bitCnt == 3'h7) begin
         byteHold_q <= {r_q.shiftIn, din};
      end
   end

   // Falling SCLK: drive read data
   always_comb begin
      f_d = f_q;
      f_d.outShift = {f_q.outShift[6:0], 1'b0};
      if (r_q.bitCnt == 3'h0 && r_q.byteCnt != 6'h00 && r_q.cmdRead) begin
         f_d.outShift = c_q.readByte;
         f_d.oeB = ~c_q.outValid;
      end
   end

   always_ff @(negedge sclk or posedge csB) begin
      if (csB) begin
         f_q <= rtc_access_pkg::FALL_IDLE;
      end else begin
         f_q <= f_d;
      end
   end

   assign dout = f_q.outShift[7];
   assign doutOeB = f_q.oeB;

   // Core: decode, buffers, counters
   always_comb begin
      c_d = c_q;
      ramWe = 1'b0;
      ramWrAddr = 5'h00;
      ramWrData = 8'h00;
      ramRdAddr = 5'h00;
      dataIdx = c_q.fullCnt - 6'h01;
      c_d.csS1 = csB;
      c_d.csS2 = c_q.csS1;
      c_d.csPrev = c_q.csS2;
      c_d.preS1 = r_q.preLvl;
      c_d.preS2 = c_q.preS1;
      c_d.prePrev = c_q.preS2;
      c_d.fullS1 = r_q.fullLvl;
      c_d.fullS2 = c_q.fullS1;
      c_d.fullPrev = c_q.fullS2;
      csRise = c_q.csS2 & ~c_q.csPrev;
      preEv = c_q.preS2 & ~c_q.prePrev;
      fullEv = c_q.fullS2 & ~c_q.fullPrev;
      tickReq = secTick | c_q.tickPend;
      timeLoad = csRise && !c_q.wp &&
         (c_q.burstDone || c_q.tmask != 7'h00);
      tickApply = tickReq && !timeLoad;
      c_d.tickPend = tickReq && timeLoad;
      if (timeLoad) begin
         for (int i = 0; i < 7; i++) begin
            if (c_q.burstDone || c_q.tmask[i]) begin
               c_d.timeR[i] = c_q.tbuf[i];
            end
         end
      end
      if (tickApply) begin
         c_d.timeR = incTime(c_q.timeR);
      end
      if (csRise) begin
         if (c_q.burstDone || c_q.ctlValid) begin
            c_d.wp = c_q.ctlBuf[rtc_access_pkg::WP_BIT];
         end
         if (c_q.centValid && !c_q.wp) begin
            c_d.century = c_q.centBuf;
         end
         c_d.tmask = 7'h00;
         c_d.ctlValid = 1'b0;
         c_d.centValid = 1'b0;
         c_d.burstDone = 1'b0;
         c_d.preCnt = 6'h00;
         c_d.fullCnt = 6'h00;
         c_d.cmd = 8'h00;
         c_d.outValid = 1'b0;
      end
      if (fullEv) begin
         if (c_q.fullCnt != rtc_access_pkg::COUNT_MAX) begin
            c_d.fullCnt = c_q.fullCnt + 6'h01;
         end
         if (c_q.fullCnt == 6'h00) begin
            c_d.cmd = byteHold_q;
         end else if (!c_q.cmd[rtc_access_pkg::CMD_READ_BIT] &&
            c_q.cmd[rtc_access_pkg::CMD_WEN_BIT]) begin
            if (c_q.cmd[rtc_access_pkg::CMD_RAM_BIT]) begin
               if (isBurst(c_q.cmd)) begin
                  ramWe = !c_q.wp &&
                     dataIdx < rtc_access_pkg::RAM_WORDS;
                  ramWrAddr = dataIdx[4:0];
               end else begin
                  ramWe = !c_q.wp && dataIdx == 6'h00;
                  ramWrAddr = c_q.cmd[5:1];
               end
               ramWrData = byteHold_q;
            end else if (isBurst(c_q.cmd)) begin
               if (dataIdx < rtc_access_pkg::TIME_REGS) begin
                  c_d.tbuf[dataIdx[2:0]] = byteHold_q;
               end else if (dataIdx == rtc_access_pkg::CLOCK_BURST_LAST) begin
                  c_d.ctlBuf = byteHold_q;
                  c_d.burstDone = 1'b1;
               end
            end else if (dataIdx == 6'h00) begin
               if (c_q.cmd[5:1] < rtc_access_pkg::TIME_REGS[4:0]) begin
                  c_d.tbuf[c_q.cmd[3:1]] = byteHold_q;
                  c_d.tmask[c_q.cmd[3:1]] = 1'b1;
               end else if (c_q.cmd[5:1] == rtc_access_pkg::IDX_CTRL) begin
                  c_d.ctlBuf = byteHold_q;
                  c_d.ctlValid = 1'b1;
               end else if (c_q.cmd[5:1] == rtc_access_pkg::IDX_CENTURY) begin
                  c_d.centBuf = byteHold_q;
                  c_d.centValid = 1'b1;
               end
            end
         end
      end
      if (preEv) begin
         if (c_q.preCnt != rtc_access_pkg::COUNT_MAX) begin
            c_d.preCnt = c_q.preCnt + 6'h01;
         end
         if (c_q.preCnt == 6'h00) begin
            c_d.cmd[7:1] = preHold_q;
            if (preHold_q[6:5] == 2'b10) begin
               c_d.snap = c_d.timeR;
            end
         end
         c_d.outValid = 1'b0;
         c_d.readByte = 8'h00;
         if (c_d.cmd[rtc_access_pkg::CMD_READ_BIT]) begin
            if (c_d.cmd[rtc_access_pkg::CMD_RAM_BIT]) begin
               if (isBurst(c_d.cmd)) begin
                  ramRdAddr = c_q.preCnt[4:0];
                  c_d.outValid = c_q.preCnt < rtc_access_pkg::RAM_WORDS;
               end else begin
                  ramRdAddr = c_d.cmd[5:1];
                  c_d.outValid = c_q.preCnt == 6'h00;
               end
               c_d.readByte = c_d.outValid ? ram[ramRdAddr] : 8'h00;
            end else if (isBurst(c_d.cmd)) begin
               if (c_q.preCnt < rtc_access_pkg::TIME_REGS) begin
                  c_d.readByte = c_d.snap[c_q.preCnt[2:0]];
                  c_d.outValid = 1'b1;
               end else if (c_q.preCnt == rtc_access_pkg::CLOCK_BURST_LAST) begin
                  c_d.readByte = {c_d.wp, 7'h00};
                  c_d.outValid = 1'b1;
               end
            end else if (c_q.preCnt == 6'h00) begin
               c_d.outValid = 1'b1;
               if (c_d.cmd[5:1] < rtc_access_pkg::TIME_REGS[4:0]) begin
                  c_d.readByte = c_d.snap[c_d.cmd[3:1]];
               end else if (c_d.cmd[5:1] == rtc_access_pkg::IDX_CTRL) begin
                  c_d.readByte = {c_d.wp, 7'h00};
               end else if (c_d.cmd[5:1] == rtc_access_pkg::IDX_CENTURY) begin
                  c_d.readByte = c_d.century;
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         c_q <= '0;
         c_q.csS1 <= 1'b1;
         c_q.csS2 <= 1'b1;
         c_q.csPrev <= 1'b1;
         c_q.timeR <= rtc_access_pkg::TIME_RST;
         c_q.snap <= rtc_access_pkg::TIME_RST;
         c_q.century <= rtc_access_pkg::CENTURY_RST;
         c_q.wp <= rtc_access_pkg::WP_RST;
      end else if (clkEn) begin
         c_q <= c_d;
      end
   end

   // Scratch RAM
   always_ff @(posedge ref_clk) begin
      if (clkEn && ramWe) begin
         ram[ramWrAddr] <= ramWrData;
      end
   end

   // Checks
   a_ram_wp_block: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ramWe |-> !c_q.wp)
      else $error("RAM written while protected");

   a_ram_lsb_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ramWe |-> (c_q.cmd[0] && !c_q.cmd[7] && c_q.cmd[6]))
      else $error("RAM written without write command and enable bit");

   a_short_burst_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (csRise && !c_q.burstDone && c_q.tmask == 7'h00) |-> !timeLoad)
      else $error("Time loaded from an incomplete burst");

   a_load_tick_apart: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !(timeLoad && tickApply))
      else $error("Time load coincided with a seconds increment");

   a_tick_deferred: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clkEn && timeLoad && secTick) |=> c_q.tickPend)
      else $error("Seconds increment lost at time load");

   a_burst_load_value: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (clkEn && timeLoad && c_q.burstDone) |=>
      c_q.timeR == $past(c_q.tbuf))
      else $error("Burst buffer not loaded into counters");

   a_snap_on_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clkEn && preEv && c_q.preCnt == 6'h00 && preHold_q[6:5] == 2'b10)
      |=> c_q.snap == c_q.timeR)
      else $error("Read latch does not match counters");

   a_ctrl_low_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clkEn && preEv && c_q.preCnt == 6'h00 && preHold_q == 7'h47)
      |=> c_q.outValid && c_q.readByte[6:0] == 7'h00)
      else $error("Control low bits not zero on read");

   a_ram_burst_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clkEn && preEv && c_q.cmd[7:1] == 7'h7F && c_q.preCnt >= 6'h1F)
      |=> !c_q.outValid)
      else $error("RAM burst read past last location");

   a_oe_cs_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (c_q.csS2 && c_q.csPrev) |-> doutOeB)
      else $error("Output driven with chip select high");

   a_hour_wrap24: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clkEn && tickApply && c_q.timeR[2] == 8'h23 &&
      c_q.timeR[1] == 8'h59 && c_q.timeR[0] == 8'h59)
      |=> c_q.timeR[2] == 8'h00)
      else $error("24-hour wrap wrong");

   a_hour_to_pm: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clkEn && tickApply && c_q.timeR[2] == 8'h91 &&
      c_q.timeR[1] == 8'h59 && c_q.timeR[0] == 8'h59)
      |=> c_q.timeR[2] == 8'hB2)
      else $error("12-hour step to noon wrong");

endmodule : rtc_command_access

// *** verilog/rtc_access_pkg.sv ***
// Purpose: Shared constants and state types for the RTC serial access block
// Assumes: Command byte layout, register indices and reset values as below
// Notes: Time registers are BCD; index 0 is seconds, 6 is year
package rtc_access_pkg;

   // Command byte fields
   localparam int CMD_READ_BIT = 7;
   localparam int CMD_RAM_BIT = 6;
   localparam int CMD_IDX_HI = 5;
   localparam int CMD_IDX_LO = 1;
   localparam int CMD_WEN_BIT = 0;

   // Register indices (command bits 5..1)
   localparam logic [4:0] IDX_SEC = 5'h00;
   localparam logic [4:0] IDX_MIN = 5'h01;
   localparam logic [4:0] IDX_HOUR = 5'h02;
   localparam logic [4:0] IDX_CTRL = 5'h07;
   localparam logic [4:0] IDX_CENTURY = 5'h09;
   localparam logic [4:0] IDX_BURST = 5'h1F;

   // Transfer sizes
   localparam logic [5:0] TIME_REGS = 6'h07;
   localparam logic [5:0] CLOCK_BURST_LAST = 6'h07;
   localparam logic [5:0] RAM_WORDS = 6'h1F;
   localparam logic [5:0] COUNT_MAX = 6'h3F;

   // Field positions
   localparam int HOUR_FMT_BIT = 7;
   localparam int HOUR_PM_BIT = 5;
   localparam int WP_BIT = 7;

   // BCD limits
   localparam logic [7:0] SEC_MAX = 8'h59;
   localparam logic [7:0] HOUR24_MAX = 8'h23;
   localparam logic [7:0] HOUR12_MAX = 8'h12;
   localparam logic [7:0] HOUR12_MIN = 8'h01;
   localparam logic [7:0] HOUR11 = 8'h11;
   localparam logic [7:0] BCD_ZERO = 8'h00;

   // Values after reset
   localparam logic [6:0][7:0] TIME_RST =
      {8'h70, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CENTURY_RST = 8'h19;
   localparam logic WP_RST = 1'b0;

   // Link state clocked on rising SCLK
   typedef struct packed {
      logic [6:0] shiftIn;
      logic [2:0] bitCnt;
      logic [5:0] byteCnt;
      logic cmdRead;
      logic preLvl;
      logic fullLvl;
   } rise_t;

   // Link state clocked on falling SCLK
   typedef struct packed {
      logic [7:0] outShift;
      logic oeB;
   } fall_t;

   localparam fall_t FALL_IDLE = '{outShift: 8'h00, oeB: 1'b1};

   // Core state on ref_clk
   typedef struct packed {
      logic csS1;
      logic csS2;
      logic csPrev;
      logic preS1;
      logic preS2;
      logic prePrev;
      logic fullS1;
      logic fullS2;
      logic fullPrev;
      logic [7:0] cmd;
      logic [5:0] preCnt;
      logic [5:0] fullCnt;
      logic [6:0][7:0] timeR;
      logic [7:0] century;
      logic wp;
      logic [6:0][7:0] snap;
      logic [6:0][7:0] tbuf;
      logic [6:0] tmask;
      logic [7:0] ctlBuf;
      logic ctlValid;
      logic [7:0] centBuf;
      logic centValid;
      logic burstDone;
      logic tickPend;
      logic [7:0] readByte;
      logic outValid;
   } core_t;

endpackage : rtc_access_pkg

// *** bench/spi_master_model.sv ***
// Purpose: SPI master partner driving the RTC serial link
// Assumes: CPOL=1 CPHA=1, 160 ns SCLK period
// Notes: SCLK idles high; din toggles between frames
`timescale 1ns/100ps

module spi_master_model (
   output logic sclk,
   output logic csB,
   output logic din,
   input wire logic dout,
   input wire logic doutOeB
);
   logic [7:0] txQ[$];
   logic [7:0] rxQ[$];
   logic idleQ[$];

   initial begin
      sclk = 1'b1;
      csB = 1'b1;
      din = 1'b0;
   end

   // Command then n bytes, one frame
   task automatic xfer(input logic [7:0] cmd, input int n);
      logic [7:0] b;
      logic [7:0] r;
      logic idle;
      r = 8'h5A;
      rxQ.delete();
      idleQ.delete();
      csB = 1'b0;
      #120;
      for (int j = 0; j <= n; j++) begin
         b = (j == 0) ? cmd : (txQ.size() > 0 ? txQ.pop_front() : ~r);
         idle = 1'b1;
         for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            din = b[i];
            #80;
            r[i] = doutOeB ? ~dout : dout; // Released line reads wrong
            idle &= doutOeB;
            sclk = 1'b1;
            #80;
         end
         if (j > 0) begin
            rxQ.push_back(r);
            idleQ.push_back(idle);
         end
      end
      #120;
      csB = 1'b1;
      din = ~din;
      #200;
   endtask : xfer
endmodule : spi_master_model

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the RTC command access block
// Assumes: Partner master model drives the serial link
// Notes: Expected values come from a behavioural register model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   mismatches++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
   logic ref_clk, rst_b, clkEn, secTick;
   logic sclk, csB, din, dout, doutOeB;
   int mismatches, comparisons, seed;
   logic [7:0] tm[8];
   logic [7:0] ram[31];
   logic [7:0] d[$];

   rtc_command_access DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .clkEn(clkEn), .secTick(secTick), .sclk(sclk), .csB(csB),
      .din(din), .dout(dout), .doutOeB(doutOeB));
   spi_master_model master (.sclk(sclk), .csB(csB), .din(din),
      .dout(dout), .doutOeB(doutOeB));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   // Write frame; output must stay idle, then recovery wait
   task automatic send(input logic [7:0] cmd, input logic [7:0] q[$]);
      master.txQ = q;
      master.xfer(cmd, q.size());
      foreach (master.idleQ[i]) `CHK("idle", 1'b1, master.idleQ[i])
      #45000;
   endtask : send

   // Read frame compared with expected bytes
   task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
      master.xfer(cmd, e.size());
      foreach (e[i]) `CHK("rdata", e[i], master.rxQ[i])
   endtask : rd

   task automatic chkTime;
      rd(8'hBF, '{tm[0], tm[1], tm[2], tm[3], tm[4], tm[5], tm[6], tm[7]});
   endtask : chkTime

   // Burst set to hh:59:59, one tick, then read the rolled-over time
   task automatic roll(input logic [7:0] h, input logic [7:0] hNext);
      d = '{8'h59, 8'h59, h, tm[3], tm[4], tm[5], tm[6], 8'h00};
      send(8'h3F, d);
      @(negedge ref_clk);
      secTick = 1'b1;
      @(negedge ref_clk);
      secTick = 1'b0;
      tm[0] = 8'h00;
      tm[1] = 8'h00;
      tm[2] = hNext;
      chkTime();
   endtask : roll

   // Model of a committed register write
   function automatic void mw(input int idx, input logic [7:0] val);
      if (!tm[7][7] || idx == 7)
         tm[idx] = (idx == 7) ? {val[7], 7'h00} : val;
   endfunction : mw

   initial begin
      #2000000;
      mismatches++;
      test_done();
   end

   initial begin
      seed = 32'h500a;
      rst_b = 1'b0;
      clkEn = 1'b1;
      secTick = 1'b0;
      for (int i = 0; i < 7; i++) tm[i] = rtc_access_pkg::TIME_RST[i];
      tm[7] = 8'h00;
      repeat (12) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      chkTime();
      d = '{8'h31, 8'h11, 8'hB0, 8'h04, 8'h07, 8'h05, 8'h02, 8'h00};
      send(8'h3F, d);
      foreach (d[i]) mw(i, d[i]);
      chkTime();
      send(8'h3F, '{8'h12, 8'h34, 8'h05, 8'h06, 8'h07});
      chkTime();
      // Tick close to the load must count from the new seconds
      for (int k = 3; k < 6; k++) begin
         fork
            send(8'h01, '{8'h45});
            begin
               @(posedge csB);
               repeat (k) @(negedge ref_clk);
               secTick = 1'b1;
               @(negedge ref_clk);
               secTick = 1'b0;
            end
         join
         tm[0] = 8'h46;
         rd(8'h81, '{tm[0]});
      end
      // Ticks are ignored while the clock enable is low
      @(negedge ref_clk);
      clkEn = 1'b0;
      secTick = 1'b1;
      @(negedge ref_clk);
      secTick = 1'b0;
      @(negedge ref_clk);
      clkEn = 1'b1;
      rd(8'h81, '{tm[0]});
      send(8'h02, '{8'h77});
      send(8'h03, '{8'h22});
      mw(1, 8'h22);
      send(8'h05, '{8'h23});
      mw(2, 8'h23);
      chkTime();
      roll(8'h23, 8'h00);
      roll(8'h91, 8'hB2);
      d.delete();
      for (int i = 0; i < 31; i++) begin
         ram[i] = 8'($random(seed));
         d.push_back(ram[i]);
      end
      send(8'h7F, d);
      master.xfer(8'hFF, 32);
      for (int i = 0; i < 31; i++)
         `CHK("ram", ram[i], master.rxQ[i])
      `CHK("tail", 1'b1, master.idleQ[31])
      ram[0] = 8'($random(seed));
      ram[1] = 8'($random(seed));
      send(8'h7F, '{ram[0], ram[1]});
      rd(8'hFF, '{ram[0], ram[1]});
      rd(8'hC3, '{ram[1]});
      send(8'h0F, '{8'hFF});
      mw(7, 8'hFF);
      send(8'h05, '{8'h08});
      mw(2, 8'h08);
      send(8'h41, '{~ram[0]});
      rd(8'hC1, '{ram[0]});
      chkTime();
      send(8'h0F, '{8'h00});
      mw(7, 8'h00);
      rd(8'h8F, '{tm[7]});
      test_done();
   end
endmodule : tb
